// *** rtl/health_attribute_record_builder.sv ***
// health attribute records: spare, worst chip, erase life, ecc and crc counters
`timescale 1ns/1ns
`default_nettype none
module health_attribute_record_builder (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire health_pkg::spare_t [health_pkg::CHIPS-1:0] spare_init_in,
	input wire health_pkg::spare_t [health_pkg::CHIPS-1:0] spare_cur_in,
	input wire logic [health_pkg::ERASE_W-1:0] erase_total_in,
	input wire logic [health_pkg::ERASE_W-1:0] erase_budget_in,
	input wire logic ecc_corr_in,
	input wire logic ecc_uncorr_in,
	input wire logic crc_err_in,
	input wire logic [7:0] spare_thr_in,
	input wire logic [7:0] erase_thr_in,
	input wire logic rd_req_in,
	input wire logic [health_pkg::ADDR_W-1:0] rd_addr_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic thr_exceeded_out
);
	localparam int C = health_pkg::CHIPS;
	localparam int SW = health_pkg::SPARE_W;
	localparam int CW = health_pkg::CNT_W;

	// per-chip spare percentage
	logic [7:0] chip_pct [C];
	logic [C-1:0] chip_done;

	genvar g;
	generate
		for (g = 0; g < C; g++) begin : g_chip
			pct_div #(.W(SW)) u_pct (
				.clk_in(clk_in),
				.sys_rst_in(sys_rst_in),
				.num_in(spare_cur_in[g]),
				.den_in(spare_init_in[g]),
				.pct_out(chip_pct[g]),
				.done_out(chip_done[g])
			);
		end
	endgenerate

	logic [7:0] erase_used_pct;
	logic erase_done;

	pct_div #(.W(health_pkg::ERASE_W)) u_erase (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.num_in(erase_total_in),
		.den_in(erase_budget_in),
		.pct_out(erase_used_pct),
		.done_out(erase_done)
	);

	// minimum percentage, sums and the chip with fewest current spares
	logic [7:0] spare_min;
	logic [23:0] init_sum;
	logic [23:0] cur_sum;
	health_pkg::spare_t worst_init;
	health_pkg::spare_t worst_cur;

	always_comb begin
		spare_min = chip_pct[0];
		init_sum = 24'h000000;
		cur_sum = 24'h000000;
		worst_init = spare_init_in[0];
		worst_cur = spare_cur_in[0];
		for (int i = 0; i < C; i++) begin
			if (chip_pct[i] < spare_min)
				spare_min = chip_pct[i];
			init_sum = init_sum + 24'(spare_init_in[i]);
			cur_sum = cur_sum + 24'(spare_cur_in[i]);
			if (spare_cur_in[i] < worst_cur) begin
				worst_cur = spare_cur_in[i];
				worst_init = spare_init_in[i];
			end
		end
	end

	// remaining life is the complement of the used fraction
	wire [7:0] life_pct = health_pkg::PCT_FULL - erase_used_pct;

	// current and worst values of the computed pre-fail records
	logic [7:0] spare_val_r;
	logic [7:0] spare_worst_r;
	logic [7:0] life_val_r;
	logic [7:0] life_worst_r;
	logic spare_ok_r;
	logic life_ok_r;

	// all chips share one divider timing, so chip 0 marks a fresh minimum
	wire spare_upd = chip_done[0];

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			spare_val_r <= health_pkg::WORST_RST;
			spare_worst_r <= health_pkg::WORST_RST;
			life_val_r <= health_pkg::WORST_RST;
			life_worst_r <= health_pkg::WORST_RST;
			spare_ok_r <= 1'b0;
			life_ok_r <= 1'b0;
		end else begin
			if (spare_upd) begin
				spare_val_r <= spare_min;
				spare_ok_r <= 1'b1;
				if (spare_min < spare_worst_r)
					spare_worst_r <= spare_min;
			end
			if (erase_done) begin
				life_val_r <= life_pct;
				life_ok_r <= 1'b1;
				if (life_pct < life_worst_r)
					life_worst_r <= life_pct;
			end
		end
	end

	// error counters saturate rather than wrap so a full count never looks healthy
	logic [CW-1:0] ecc_total_r;
	logic [CW-1:0] ecc_corr_r;
	logic [CW-1:0] crc_r;

	wire [1:0] ecc_inc = {1'b0, ecc_corr_in} + {1'b0, ecc_uncorr_in};
	wire [CW:0] ecc_total_sum = {1'b0, ecc_total_r} + (CW+1)'(ecc_inc);
	wire [CW-1:0] ecc_total_nxt = ecc_total_sum[CW] ? '1 : ecc_total_sum[CW-1:0];
	wire ecc_corr_full = &ecc_corr_r;
	wire crc_full = &crc_r;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ecc_total_r <= '0;
			ecc_corr_r <= '0;
			crc_r <= '0;
		end else begin
			ecc_total_r <= ecc_total_nxt;
			if (ecc_corr_in && !ecc_corr_full)
				ecc_corr_r <= ecc_corr_r + CW'(1);
			if (crc_err_in && !crc_full)
				crc_r <= crc_r + CW'(1);
		end
	end

	// record assembly
	health_pkg::attr_rec_s rec [health_pkg::NUM_REC];

	assign rec[health_pkg::SLOT_SPARE] = '{
		rsvd: health_pkg::RSVD_VAL,
		raw: {cur_sum, init_sum},
		worst: spare_worst_r,
		cur: spare_val_r,
		flags: health_pkg::FLAGS_PREFAIL,
		id: health_pkg::ID_SPARE};

	assign rec[health_pkg::SLOT_WORST] = '{
		rsvd: health_pkg::RSVD_VAL,
		raw: {8'h00, worst_cur, 8'h00, worst_init},
		worst: health_pkg::FIXED_VAL,
		cur: health_pkg::FIXED_VAL,
		flags: health_pkg::FLAGS_PREFAIL,
		id: health_pkg::ID_WORST_CHIP};

	assign rec[health_pkg::SLOT_ERASE] = '{
		rsvd: health_pkg::RSVD_VAL,
		raw: erase_total_in,
		worst: life_worst_r,
		cur: life_val_r,
		flags: health_pkg::FLAGS_PREFAIL,
		id: health_pkg::ID_ERASE};

	assign rec[health_pkg::SLOT_ECC_TOTAL] = '{
		rsvd: health_pkg::RSVD_VAL,
		raw: {16'h0000, ecc_total_r},
		worst: health_pkg::FIXED_VAL,
		cur: health_pkg::FIXED_VAL,
		flags: health_pkg::FLAGS_ADVISORY,
		id: health_pkg::ID_ECC_TOTAL};

	assign rec[health_pkg::SLOT_ECC_CORR] = '{
		rsvd: health_pkg::RSVD_VAL,
		raw: {16'h0000, ecc_corr_r},
		worst: health_pkg::FIXED_VAL,
		cur: health_pkg::FIXED_VAL,
		flags: health_pkg::FLAGS_ADVISORY,
		id: health_pkg::ID_ECC_CORR};

	assign rec[health_pkg::SLOT_CRC] = '{
		rsvd: health_pkg::RSVD_VAL,
		raw: {16'h0000, crc_r},
		worst: health_pkg::FIXED_VAL,
		cur: health_pkg::FIXED_VAL,
		flags: health_pkg::FLAGS_ADVISORY,
		id: health_pkg::ID_CRC};

	// byte read decode; unused slots and bytes outside the area read zero
	wire in_area = rd_addr_in >= health_pkg::ATTR_BASE && rd_addr_in <= health_pkg::ATTR_LAST;
	wire [health_pkg::ADDR_W-1:0] area_off = rd_addr_in - health_pkg::ATTR_BASE;
	wire [4:0] slot = 5'(area_off / 9'(health_pkg::REC_BYTES_5));
	wire [3:0] byte_sel = 4'(area_off % 9'(health_pkg::REC_BYTES_5));
	wire slot_used = slot < 5'(health_pkg::NUM_REC);
	wire [95:0] rec_bits = slot_used ? rec[3'(slot)] : 96'h0;
	wire [7:0] rd_byte = in_area ? rec_bits[8*byte_sel +: 8] : 8'h00;

	// status compares only the pre-fail values, once each has been computed
	wire spare_bad = spare_ok_r && (spare_val_r < spare_thr_in);
	wire life_bad = life_ok_r && (life_val_r < erase_thr_in);

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_data_out <= 8'h00;
			rd_valid_out <= 1'b0;
			thr_exceeded_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_req_in;
			if (rd_req_in)
				rd_data_out <= rd_byte;
			thr_exceeded_out <= spare_bad || life_bad;
		end
	end
endmodule
`default_nettype wire

// *** rtl/health_pkg.sv ***
// constants and record layout shared by the health attribute record builder
package health_pkg;
	localparam int CHIPS = 4;
	localparam int SPARE_W = 16;
	localparam int ERASE_W = 48;
	localparam int CNT_W = 32;
	localparam int ADDR_W = 9;

	localparam logic [7:0] ID_SPARE = 8'hc4;
	localparam logic [7:0] ID_WORST_CHIP = 8'hd5;
	localparam logic [7:0] ID_ERASE = 8'he5;
	localparam logic [7:0] ID_ECC_TOTAL = 8'hcb;
	localparam logic [7:0] ID_ECC_CORR = 8'hcc;
	localparam logic [7:0] ID_CRC = 8'hc7;

	localparam logic [15:0] FLAGS_PREFAIL = 16'h0003;
	localparam logic [15:0] FLAGS_ADVISORY = 16'h0002;
	localparam logic [7:0] FIXED_VAL = 8'h64;
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] WORST_RST = 8'h64;
	localparam logic [7:0] RSVD_VAL = 8'h00;

	localparam int REC_BYTES = 12;
	localparam int NUM_REC = 6;
	localparam logic [ADDR_W-1:0] ATTR_BASE = 9'h002;
	localparam logic [ADDR_W-1:0] ATTR_LAST = 9'h169;
	localparam logic [4:0] REC_BYTES_5 = 5'h0c;

	localparam logic [3:0] QBITS = 4'h8;
	localparam logic [6:0] PCT_MUL = 7'h64;

	// record slot order inside the attribute area
	localparam int SLOT_SPARE = 0;
	localparam int SLOT_WORST = 1;
	localparam int SLOT_ERASE = 2;
	localparam int SLOT_ECC_TOTAL = 3;
	localparam int SLOT_ECC_CORR = 4;
	localparam int SLOT_CRC = 5;

	typedef enum logic {DIV_LOAD, DIV_RUN} div_state_e;

	// packed so that byte k of the record sits at bits 8k+7:8k (lsb first)
	typedef struct packed {
		logic [7:0] rsvd;
		logic [47:0] raw;
		logic [7:0] worst;
		logic [7:0] cur;
		logic [15:0] flags;
		logic [7:0] id;
	} attr_rec_s;

	typedef logic [SPARE_W-1:0] spare_t;
endpackage

// *** rtl/pct_div.sv ***
// free-running percentage divider: floor(100*num/den), capped at 100
`timescale 1ns/1ns
`default_nettype none
module pct_div #(
	parameter int W = 16
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [W-1:0] num_in,
	input wire logic [W-1:0] den_in,
	output logic [7:0] pct_out,
	output logic done_out
);
	localparam int WX = W + 8;

	health_pkg::div_state_e state_r;
	logic [WX-1:0] rem_r;
	logic [WX-1:0] den_r;
	logic [7:0] q_r;
	logic [3:0] bit_r;
	logic ovf_r;
	logic zero_r;

	wire [3:0] bit_idx = bit_r - 4'h1;
	wire [WX-1:0] trial = den_r << bit_idx;
	wire take = rem_r >= trial;
	wire [WX-1:0] num_x = {{(WX-W){1'b0}}, num_in};
	wire [WX-1:0] den_x = {{(WX-W){1'b0}}, den_in};
	wire [WX-1:0] scaled = WX'(num_x * WX'(health_pkg::PCT_MUL));
	wire [7:0] q_nxt = take ? (q_r | (8'h01 << bit_idx)) : q_r;
	wire last = bit_r == 4'h1;
	wire [7:0] capped = (ovf_r || q_nxt > health_pkg::PCT_FULL) ? health_pkg::PCT_FULL : q_nxt;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r <= health_pkg::DIV_LOAD;
			rem_r <= '0;
			den_r <= '0;
			q_r <= 8'h00;
			bit_r <= 4'h0;
			ovf_r <= 1'b0;
			zero_r <= 1'b0;
			pct_out <= 8'h00;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state_r)
				health_pkg::DIV_LOAD: begin
					// sample inputs once per pass so a moving count gives a coherent result
					rem_r <= scaled;
					den_r <= den_x;
					q_r <= 8'h00;
					bit_r <= health_pkg::QBITS;
					ovf_r <= scaled >= (den_x << health_pkg::QBITS);
					zero_r <= den_in == '0;
					state_r <= health_pkg::DIV_RUN;
				end
				health_pkg::DIV_RUN: begin
					if (take)
						rem_r <= rem_r - trial;
					q_r <= q_nxt;
					bit_r <= bit_idx;
					if (last) begin
						pct_out <= zero_r ? 8'h00 : capped;
						done_out <= 1'b1;
						state_r <= health_pkg::DIV_LOAD;
					end
				end
				default: state_r <= health_pkg::DIV_LOAD;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** verif/record_checker_assertions.sv ***
// concurrent checks on the byte read port of the health record builder
`timescale 1ns/1ns
`default_nettype none
module record_checker (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic rd_req_in,
	input wire logic [health_pkg::ADDR_W-1:0] rd_addr_in,
	input wire logic [7:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic thr_exceeded_out
);
	localparam logic [47:0] IDS = 48'hc7_cc_cb_e5_d5_c4;
	logic [8:0] off;
	logic [8:0] slot;
	logic [8:0] byt;
	logic in_rec;
	logic [7:0] id_exp;
	logic [7:0] flag_exp;
	// only the six filled slots are decoded; the other 24 must read zero
	assign off = rd_addr_in - 9'h002;
	assign slot = off / 9'h00c;
	assign byt = off % 9'h00c;
	assign in_rec = rd_addr_in >= 9'h002 && rd_addr_in < 9'h04a;
	assign id_exp = IDS[8*slot[2:0] +: 8];
	assign flag_exp = slot < 9'h003 ? 8'h03 : 8'h02;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_valid_follows_req: assert property (
		rd_req_in |=> rd_valid_out) else $error("read not answered");
	a_valid_only_req: assert property (
		!rd_req_in |=> !rd_valid_out) else $error("valid without read");
	a_data_holds: assert property (
		!rd_req_in |=> $stable(rd_data_out)) else $error("read data moved");
	a_outside_zero: assert property (
		rd_req_in && !in_rec |=> rd_data_out == 8'h00) else $error("unused byte not zero");
	a_reserved_zero: assert property (
		rd_req_in && in_rec && byt == 9'h00b |=> rd_data_out == 8'h00) else $error("byte 11");
	a_record_id: assert property (
		rd_req_in && in_rec && byt == 9'h000 |=> rd_data_out == $past(id_exp))
		else $error("wrong record id");
	a_flag_low: assert property (
		rd_req_in && in_rec && byt == 9'h001 |=> rd_data_out == $past(flag_exp))
		else $error("wrong flags");
	a_flag_high: assert property (
		rd_req_in && in_rec && byt == 9'h002 |=> rd_data_out == 8'h00) else $error("flags high");
	a_fixed_value: assert property (
		rd_req_in && in_rec && (slot == 9'h001 || slot > 9'h002) && (byt == 9'h003 ||
		byt == 9'h004) |=> rd_data_out == 8'h64) else $error("fixed value not 64h");
	a_upper_unused: assert property (
		rd_req_in && in_rec && slot > 9'h002 && (byt == 9'h009 || byt == 9'h00a)
		|=> rd_data_out == 8'h00) else $error("unused counter bytes");
	c_back_to_back: cover property (rd_req_in ##1 rd_req_in);
	c_thr_rise: cover property ($rose(thr_exceeded_out));
	c_spare_value: cover property (rd_req_in && in_rec && slot == 9'h000 && byt == 9'h003);
endmodule
bind health_attribute_record_builder record_checker record_checker_inst (
	.clk_in(clk_in),
	.sys_rst_in(sys_rst_in),
	.rd_req_in(rd_req_in),
	.rd_addr_in(rd_addr_in),
	.rd_data_out(rd_data_out),
	.rd_valid_out(rd_valid_out),
	.thr_exceeded_out(thr_exceeded_out)
);
`default_nettype wire

// *** verif/host_reader.sv ***
// host side model that fetches one twelve-byte record over the read port
`timescale 1ns/1ns
`default_nettype none
module host_reader (
	input wire logic clk_in,
	input wire logic [7:0] rd_data_in,
	input wire logic rd_valid_in,
	output logic rd_req_out,
	output logic [health_pkg::ADDR_W-1:0] rd_addr_out,
	output health_pkg::attr_rec_s rec_out
);
	int got;
	initial begin
		rd_req_out = 1'b0;
		rd_addr_out = '0;
		rec_out = '0;
	end
	// look one time unit after the edge, once the registered answer has settled
	task automatic take();
		@(posedge clk_in);
		#1;
		if (rd_valid_in === 1'b1) begin
			rec_out[8*got +: 8] = rd_data_in;
			got++;
		end
	endtask
	// slow mode leaves an idle cycle after each byte; valid is low then, so take stores nothing
	task automatic fetch(input logic [8:0] base, input bit slow);
		got = 0;
		// cleared so that a byte that never arrives cannot pass on stale data
		rec_out = '0;
		for (int i = 0; i < 12; i++) begin
			rd_req_out = 1'b1;
			rd_addr_out = base + 9'(i);
			take();
			if (slow) begin
				rd_req_out = 1'b0;
				rd_addr_out = ~rd_addr_out;
				take();
			end
		end
		rd_req_out = 1'b0;
		rd_addr_out = ~rd_addr_out;
		take();
	endtask
endmodule
`default_nettype wire

// *** verif/health_attribute_record_builder_bench.sv ***
// self-checking bench for the health attribute record builder
`timescale 1ns/1ns
`default_nettype none
module health_attribute_record_builder_bench;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	health_pkg::spare_t [3:0] spare_init_in = {16'h0190, 16'h0032, 16'h0064, 16'h00c8};
	health_pkg::spare_t [3:0] spare_cur_in = {16'h0190, 16'h000a, 16'h0050, 16'h0096};
	logic [47:0] erase_total_in = 48'h00000000012c;
	logic [47:0] erase_budget_in = 48'h0000000003e8;
	logic [2:0] err_in = 3'h0;
	logic [7:0] spare_thr_in = 8'h0a;
	logic [7:0] erase_thr_in = 8'h32;
	wire logic rd_req_in;
	wire logic [8:0] rd_addr_in;
	wire logic [7:0] rd_data_out;
	wire logic rd_valid_out;
	wire logic thr_exceeded_out;
	wire health_pkg::attr_rec_s rec;
	int n_fail = 0;
	int samples_checked = 0;
	health_pkg::attr_rec_s rows[6] = '{
		{8'h00, 48'h000280_0002ee, 8'h14, 8'h14, 16'h0003, 8'hc4},
		{8'h00, 48'h00000a_000032, 8'h64, 8'h64, 16'h0003, 8'hd5},
		{8'h00, 48'h00000000012c, 8'h46, 8'h46, 16'h0003, 8'he5},
		{8'h00, 48'h000000000004, 8'h64, 8'h64, 16'h0002, 8'hcb},
		{8'h00, 48'h000000000002, 8'h64, 8'h64, 16'h0002, 8'hcc},
		{8'h00, 48'h000000000002, 8'h64, 8'h64, 16'h0002, 8'hc7}};
	logic [16:0] thr_rows[4] = '{{8'h15, 8'h32, 1'b1}, {8'h14, 8'h32, 1'b0},
		{8'h0a, 8'h47, 1'b1}, {8'h0a, 8'h46, 1'b0}};
	health_attribute_record_builder health_attribute_record_builder_inst (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.spare_init_in(spare_init_in),
		.spare_cur_in(spare_cur_in),
		.erase_total_in(erase_total_in),
		.erase_budget_in(erase_budget_in),
		.ecc_corr_in(err_in[2]),
		.ecc_uncorr_in(err_in[1]),
		.crc_err_in(err_in[0]),
		.spare_thr_in(spare_thr_in),
		.erase_thr_in(erase_thr_in),
		.rd_req_in(rd_req_in),
		.rd_addr_in(rd_addr_in),
		.rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out),
		.thr_exceeded_out(thr_exceeded_out)
	);
	host_reader host_reader_inst (
		.clk_in(clk_in),
		.rd_data_in(rd_data_out),
		.rd_valid_in(rd_valid_out),
		.rd_req_out(rd_req_in),
		.rd_addr_out(rd_addr_in),
		.rec_out(rec)
	);
	initial forever #4 clk_in = ~clk_in;
	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
	initial begin
		step(3);
		sys_rst_in = 1'b0;
		check({rd_data_out, rd_valid_out, thr_exceeded_out}, 96'h0);
		// both ecc kinds in one cycle must add two to the total count
		err_in = 3'h6;
		step(1);
		err_in = 3'h4;
		step(1);
		err_in = 3'h3;
		step(1);
		err_in = 3'h1;
		step(1);
		err_in = 3'h0;
		step(40);
		check(thr_exceeded_out, 96'h0);
		for (int i = 0; i < 6; i++) begin
			host_reader_inst.fetch(9'(2 + 12 * i), 1'b0);
			check(rec, rows[i]);
		end
		foreach (thr_rows[i]) begin
			step(1);
			{spare_thr_in, erase_thr_in} = thr_rows[i][16:1];
			step(3);
			check(thr_exceeded_out, 96'(thr_rows[i][0]));
		end
		spare_cur_in[2] = 16'h0028;
		erase_total_in = 48'h000000000320;
		step(40);
		check(thr_exceeded_out, 96'h1);
		erase_total_in = 48'h00000000012c;
		step(40);
		host_reader_inst.fetch(9'h002, 1'b0);
		check(rec, {8'h00, 48'h00029e_0002ee, 8'h14, 8'h4b, 16'h0003, 8'hc4});
		host_reader_inst.fetch(9'h01a, 1'b0);
		check(rec, {8'h00, 48'h00012c, 8'h14, 8'h46, 16'h0003, 8'he5});
		host_reader_inst.fetch(9'h000, 1'b1);
		check(rec[31:0], 96'h03c40000);
		foreach (rows[i]) if (i < 3) begin
			host_reader_inst.fetch(i == 0 ? 9'h04a : i == 1 ? 9'h15e : 9'h1f4, 1'b0);
			check(rec, 96'h0);
		end
		// mid-run reset clears counters and worst values; zero divisors are handled
		sys_rst_in = 1'b1;
		spare_init_in[3] = 16'h0000;
		erase_budget_in = 48'h000000000000;
		step(3);
		sys_rst_in = 1'b0;
		check(thr_exceeded_out, 96'h0);
		host_reader_inst.fetch(9'h026, 1'b0);
		check(rec, {8'h00, 48'h0, 8'h64, 8'h64, 16'h0002, 8'hcb});
		step(40);
		check(thr_exceeded_out, 96'h1);
		host_reader_inst.fetch(9'h002, 1'b0);
		check(rec, {8'h00, 48'h00029e_00015e, 8'h00, 8'h00, 16'h0003, 8'hc4});
		host_reader_inst.fetch(9'h01a, 1'b0);
		check(rec, {8'h00, 48'h00012c, 8'h64, 8'h64, 16'h0003, 8'he5});
		summarize();
	end
endmodule
`default_nettype wire
